// ### rtl/dca_pkg.sv
// Shared constants for the dual-port stream aggregator: frame layouts,
// register indices, reset values, strap codes and timing counts.
// Assumes a 200 MHz system clock; all times are converted here.
package dca_pkg;
	localparam int NPORT = 2;
	localparam int CLK_NS = 5;

	// Link frames
	localparam int FRAME_W = 40;
	localparam int FCNT_W = 6;
	localparam logic [FCNT_W-1:0] FLEN_CSI = 6'd40;
	localparam logic [FCNT_W-1:0] FLEN_RAW = 6'd28;
	localparam logic [FRAME_W-1:0] PMASK_CSI = 40'h7F_FFFF_FFFF;
	localparam logic [FRAME_W-1:0] PMASK_RAW = 40'h00_07FF_FFFF;
	localparam int CF_KIND = 36;
	localparam int CF_LAST = 35;
	localparam int CF_FWD = 34;
	localparam int RF_FWD = 25;
	localparam int RF_VS = 13;
	localparam int RF_HS = 12;
	localparam int RF_PIX_W = 12;
	localparam logic [1:0] KIND_IDLE = 2'h0;
	localparam logic [1:0] KIND_SHORT = 2'h1;
	localparam logic [1:0] KIND_LHDR = 2'h2;
	localparam logic [1:0] KIND_DATA = 2'h3;

	// Packet header {ecc, word count, vc, data type}
	localparam int HDR_VC = 6;
	localparam int HDR_DT_W = 6;
	localparam logic [5:0] DT_FS = 6'h00;
	localparam logic [5:0] DT_FE = 6'h01;

	// Receive input modes and strap codes
	localparam logic [1:0] RXM_CSI = 2'h0;
	localparam logic [1:0] RXM_RAW12LF = 2'h1;
	localparam logic [1:0] RXM_RAW12HF = 2'h2;
	localparam logic [1:0] RXM_RAW10 = 2'h3;
	localparam logic [2:0] STRAP_CSI_ASYNC = 3'h0;
	localparam logic [2:0] STRAP_RAW12LF = 3'h1;
	localparam logic [2:0] STRAP_RAW12HF = 3'h2;
	localparam logic [2:0] STRAP_RAW10 = 3'h3;
	localparam logic [2:0] STRAP_CSI_SYNC = 3'h4;

	// Register indices (byte address is four times the index)
	localparam logic [7:0] REG_CTRL = 8'h20;
	localparam logic [7:0] REG_STAT = 8'h21;
	localparam logic [7:0] REG_FLAGS = 8'h22;
	localparam logic [7:0] REG_BC_TX = 8'h23;
	localparam logic [7:0] REG_FWD_RX = 8'h24;
	localparam logic [7:0] REG_PORT_SEL = 8'h4C;
	localparam logic [7:0] REG_PORT_CFG = 8'h6D;
	localparam logic [7:0] REG_VC_MAP = 8'h70;
	localparam logic [7:0] REG_RAW_HDR = 8'h71;
	localparam int CTRL_DUAL = 0;
	localparam int CTRL_SYNC = 1;
	localparam int CTRL_EN = 2;
	localparam int FL_OVR = 0;
	localparam int FL_PERR = 2;
	localparam int FL_FWD = 4;
	localparam int FL_W = 6;
	localparam logic [7:0] CTRL_RST = 8'h0C;
	localparam logic [7:0] PORT_CFG_RST = 8'h00;
	localparam logic [7:0] VC_MAP_RST = 8'hE4;
	localparam logic [7:0] RAW_HDR_RST = 8'hB0;

	// Back channel: sync header, valid bit, data byte
	localparam int BC_FRAME_W = 11;
	localparam logic [1:0] BC_SYNC = 2'b10;
	localparam int BC_DIV_W = 8;
	localparam int BC_BIT_NS_SYNC = 20;
	localparam int BC_BIT_NS_ASYNC = 100;
	localparam logic [BC_DIV_W-1:0] BC_DIV_SYNC =
		BC_DIV_W'(BC_BIT_NS_SYNC / CLK_NS);
	localparam logic [BC_DIV_W-1:0] BC_DIV_ASYNC =
		BC_DIV_W'(BC_BIT_NS_ASYNC / CLK_NS);

	// Settling wait after power-down release
	localparam int PWRUP_NS = 1000000;
	localparam int PWRUP_CYC = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int PWRUP_CNT_W = 20;

	typedef enum logic [1:0] {PU_OFF, PU_WAIT, PU_RUN} dca_pu_t;
endpackage

// ### rtl/dca_rx_if.sv
// Carrier for one receive port's decoded link frames.
// Assumes producer and consumer share clk_sys_i.
`timescale 1ns/100ps
interface dca_rx_if;
	import dca_pkg::*;
	logic fv;
	logic [FRAME_W-1:0] frame;
	logic perr;
	modport src(output fv, frame, perr);
	modport dst(input fv, frame, perr);
endinterface

// ### rtl/dca_rx_port.sv
// One receive port: samples the link clock and data pins, finds frames
// of 40 or 28 bits and checks framing and parity.
// Assumes the link clock is far slower than clk_sys_i.
`timescale 1ns/100ps
module dca_rx_port import dca_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic en_i,
	input wire logic raw_i,
	input wire logic lclk_i,
	input wire logic lsd_i,
	dca_rx_if.src rx
);
	logic [2:0] clk_s;
	logic [1:0] sd_s;
	logic [FRAME_W-1:0] sh;
	logic [FRAME_W-1:0] next_sh;
	logic [FRAME_W-1:0] pmask;
	logic [FCNT_W-1:0] cnt;
	logic [FCNT_W-1:0] flen;
	logic edge_r;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			clk_s <= '0;
			sd_s <= '0;
		end else if (ce_i) begin
			clk_s <= {clk_s[1:0], lclk_i};
			sd_s <= {sd_s[0], lsd_i};
		end
	end

	assign edge_r = clk_s[1] & ~clk_s[2];
	assign next_sh = {sh[FRAME_W-2:0], sd_s[1]};
	assign flen = raw_i ? FLEN_RAW : FLEN_CSI;
	assign pmask = raw_i ? PMASK_RAW : PMASK_CSI;

	// Bit slip on a bad framing bit; the far end's transitions let it lock
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || !en_i) begin
			sh <= '0;
			cnt <= '0;
			rx.fv <= 1'b0;
			rx.perr <= 1'b0;
			rx.frame <= '0;
		end else if (ce_i) begin
			rx.fv <= 1'b0;
			rx.perr <= 1'b0;
			if (edge_r) begin
				sh <= next_sh;
				if (cnt != flen - 6'd1) begin
					cnt <= cnt + 6'd1;
				end else if (next_sh[flen - 6'd1]) begin
					cnt <= '0;
					if (^(next_sh & pmask)) begin
						rx.perr <= 1'b1;
					end else begin
						rx.fv <= 1'b1;
						rx.frame <= next_sh & pmask;
					end
				end
			end
		end
	end
endmodule

// ### rtl/dca_aggregator.sv
// Dual receive port aggregator: two link ports merged by virtual
// channel onto one four-lane or two replicated two-lane outputs, with a
// back channel per port and a classic Wishbone register slave.
// Assumes link pins are asynchronous; output lanes have no back-pressure.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
module dca_aggregator import dca_pkg::*; #(
	parameter int unsigned PWRUP_CYCLES = PWRUP_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [1:0] link_clk_i,
	input wire logic [1:0] link_sd_i,
	output logic [1:0] bc_sd_o,
	input wire logic power_down_release_pin_i,
	input wire logic [2:0] mode_strap_i,
	output logic tx_valid_o,
	output logic [31:0] tx_data_o,
	output logic tx_sop_o,
	output logic tx_last_o,
	output logic [3:0] tx_lane_en_o,
	output logic [1:0] tx_clk_lane_en_o
);
	logic [1:0] pdb_s;
	logic [2:0] strap_s1;
	logic [2:0] strap_s2;
	dca_pu_t pu_st;
	logic [PWRUP_CNT_W-1:0] pu_cnt;
	logic strap_go;
	logic ready;
	logic [7:0] ctrl;
	logic port_sel;
	logic [7:0] port_cfg [NPORT];
	logic [7:0] vc_map [NPORT];
	logic [7:0] raw_hdr [NPORT];
	logic [NPORT-1:0] port_raw;
	logic [NPORT-1:0] port_on;
	logic [NPORT-1:0] rx_fv;
	logic [NPORT-1:0] rx_perr;
	logic [FRAME_W-1:0] rx_frame [NPORT];
	logic [NPORT-1:0] raw_hs;
	logic [NPORT-1:0] raw_vs;
	logic [NPORT-1:0] nw_v;
	logic [NPORT-1:0] nw_sop;
	logic [NPORT-1:0] nw_last;
	logic [31:0] nw_word [NPORT];
	logic [NPORT-1:0] pend_v;
	logic [NPORT-1:0] pend_sop;
	logic [NPORT-1:0] pend_last;
	logic [31:0] pend_word [NPORT];
	logic locked;
	logic owner;
	logic rr_last;
	logic sel;
	logic take;
	logic half_v;
	logic half_last;
	logic [15:0] half_w;
	logic [FL_W-1:0] flags;
	logic [FL_W-1:0] fl_set;
	logic [FL_W-1:0] fl_clr;
	logic [BC_DIV_W-1:0] bc_div [NPORT];
	logic [3:0] bc_cnt [NPORT];
	logic [BC_FRAME_W-1:0] bc_sh [NPORT];
	logic [NPORT-1:0] bc_hold_v;
	logic [7:0] bc_hold_d [NPORT];
	logic [7:0] fwd_sh [NPORT];
	logic [2:0] fwd_cnt [NPORT];
	logic [7:0] fwd_byte [NPORT];
	logic wb_req;
	logic wb_wr;
	logic [7:0] idx;
	logic [31:0] rdat;
	logic [BC_DIV_W-1:0] bc_top;

	// Power-down release, 1 ms settle, then strap sample
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pdb_s <= '0;
			strap_s1 <= '0;
			strap_s2 <= '0;
		end else if (ce_i) begin
			pdb_s <= {pdb_s[0], power_down_release_pin_i};
			strap_s1 <= mode_strap_i;
			strap_s2 <= strap_s1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pu_st <= PU_OFF;
			pu_cnt <= '0;
			strap_go <= 1'b0;
		end else if (ce_i) begin
			strap_go <= 1'b0;
			case (pu_st)
			PU_OFF: begin
				pu_cnt <= '0;
				if (pdb_s[1]) pu_st <= PU_WAIT;
			end
			PU_WAIT: begin
				if (!pdb_s[1]) begin
					pu_st <= PU_OFF;
				end else if (pu_cnt == PWRUP_CNT_W'(PWRUP_CYCLES - 1)) begin
					strap_go <= 1'b1;
					pu_st <= PU_RUN;
				end else begin
					pu_cnt <= pu_cnt + 1'b1;
				end
			end
			PU_RUN: begin
				if (!pdb_s[1]) pu_st <= PU_OFF;
			end
			default: pu_st <= PU_OFF;
			endcase
		end
	end
	assign ready = (pu_st == PU_RUN);

	// Wishbone decode; one wait state, ack is a single-cycle pulse
	assign idx = wb_adr_i[9:2];
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ctrl <= CTRL_RST;
			port_sel <= 1'b0;
			for (int p = 0; p < NPORT; p++) begin
				port_cfg[p] <= PORT_CFG_RST;
				vc_map[p] <= VC_MAP_RST;
				raw_hdr[p] <= RAW_HDR_RST;
			end
		end else if (ce_i) begin
			if (strap_go) begin
				for (int p = 0; p < NPORT; p++) begin
					case (strap_s2)
					STRAP_RAW12LF: port_cfg[p][1:0] <= RXM_RAW12LF;
					STRAP_RAW12HF: port_cfg[p][1:0] <= RXM_RAW12HF;
					STRAP_RAW10: port_cfg[p][1:0] <= RXM_RAW10;
					default: port_cfg[p][1:0] <= RXM_CSI;
					endcase
				end
				ctrl[CTRL_SYNC] <= (strap_s2 == STRAP_CSI_SYNC);
			end else if (wb_wr) begin
				case (idx)
				REG_CTRL: ctrl <= wb_dat_i[7:0];
				REG_PORT_SEL: port_sel <= wb_dat_i[0];
				REG_PORT_CFG: port_cfg[port_sel] <= wb_dat_i[7:0];
				REG_VC_MAP: vc_map[port_sel] <= wb_dat_i[7:0];
				REG_RAW_HDR: raw_hdr[port_sel] <= wb_dat_i[7:0];
				default: ;
				endcase
			end
		end
	end

	always_comb begin
		rdat = '0;
		case (idx)
		REG_CTRL: rdat[7:0] = ctrl;
		REG_STAT: rdat[3:0] = {bc_hold_v, ctrl[CTRL_SYNC], ready};
		REG_FLAGS: rdat[FL_W-1:0] = flags;
		REG_FWD_RX: rdat[7:0] = fwd_byte[port_sel];
		REG_PORT_SEL: rdat[0] = port_sel;
		REG_PORT_CFG: rdat[7:0] = port_cfg[port_sel];
		REG_VC_MAP: rdat[7:0] = vc_map[port_sel];
		REG_RAW_HDR: rdat[7:0] = raw_hdr[port_sel];
		default: rdat = '0;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else if (ce_i) begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? rdat : '0;
		end
	end

	// Receive ports
	for (genvar g = 0; g < NPORT; g++) begin : g_port
		dca_rx_if rxi();
		assign port_raw[g] = port_cfg[g][1:0] != RXM_CSI;
		assign port_on[g] = ready & ctrl[CTRL_EN + g];
		dca_rx_port u_rx (
			.clk_sys_i(clk_sys_i),
			.rst_i(rst_i),
			.ce_i(ce_i),
			.en_i(port_on[g]),
			.raw_i(port_raw[g]),
			.lclk_i(link_clk_i[g]),
			.lsd_i(link_sd_i[g]),
			.rx(rxi.src)
		);
		assign rx_fv[g] = rxi.fv;
		assign rx_perr[g] = rxi.perr;
		assign rx_frame[g] = rxi.frame;
	end

	// Frame to output word; CSI payload bits pass unchanged except the remapped header VC field
	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			nw_v[p] = 1'b0;
			nw_sop[p] = 1'b0;
			nw_last[p] = 1'b0;
			nw_word[p] = rx_frame[p][31:0];
			if (rx_fv[p] && !port_raw[p]) begin
				case (rx_frame[p][CF_KIND +: 2])
				KIND_SHORT, KIND_LHDR: begin
					nw_v[p] = 1'b1;
					nw_sop[p] = 1'b1;
					nw_last[p] = rx_frame[p][CF_KIND +: 2] == KIND_SHORT;
					nw_word[p][HDR_VC +: 2] =
						vc_map[p][2 * rx_frame[p][HDR_VC +: 2] +: 2];
				end
				KIND_DATA: begin
					nw_v[p] = 1'b1;
					nw_last[p] = rx_frame[p][CF_LAST];
				end
				default: nw_v[p] = 1'b0;
				endcase
			end else if (rx_fv[p]) begin
				nw_v[p] = 1'b1;
				nw_word[p] = {8'h00, 16'h0000, raw_hdr[p][1:0],
					raw_hdr[p][7:2]};
				if (rx_frame[p][RF_VS] != raw_vs[p]) begin
					nw_sop[p] = 1'b1;
					nw_last[p] = 1'b1;
					nw_word[p][HDR_DT_W-1:0] =
						rx_frame[p][RF_VS] ? DT_FS : DT_FE;
				end else if (rx_frame[p][RF_HS] && !raw_hs[p]) begin
					nw_sop[p] = 1'b1;
				end else if (!rx_frame[p][RF_HS] && raw_hs[p]) begin
					nw_last[p] = 1'b1;
					nw_word[p] = '0;
				end else if (rx_frame[p][RF_HS]) begin
					nw_word[p] = {20'h0_0000, rx_frame[p][RF_PIX_W-1:0]};
				end else begin
					nw_v[p] = 1'b0;
				end
			end
		end
	end

	// Fair choice, held for a whole packet
	always_comb begin
		if (locked) begin
			sel = owner;
		end else begin
			sel = pend_v[~rr_last] ? ~rr_last : rr_last;
		end
		take = ~half_v & pend_v[sel];
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pend_v <= '0;
			pend_sop <= '0;
			pend_last <= '0;
			raw_hs <= '0;
			raw_vs <= '0;
			for (int p = 0; p < NPORT; p++) pend_word[p] <= '0;
		end else if (ce_i) begin
			for (int p = 0; p < NPORT; p++) begin
				if (rx_fv[p]) begin
					raw_hs[p] <= rx_frame[p][RF_HS];
					raw_vs[p] <= rx_frame[p][RF_VS];
				end
				if (nw_v[p]) begin
					pend_v[p] <= 1'b1;
					pend_sop[p] <= nw_sop[p];
					pend_last[p] <= nw_last[p];
					pend_word[p] <= nw_word[p];
				end else if (take && sel == p) begin
					pend_v[p] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			locked <= 1'b0;
			owner <= 1'b0;
			rr_last <= 1'b1;
		end else if (ce_i && take) begin
			if (pend_sop[sel]) rr_last <= sel;
			if (pend_last[sel]) begin
				locked <= 1'b0;
			end else if (pend_sop[sel]) begin
				locked <= 1'b1;
				owner <= sel;
			end
		end
	end

	// Output lanes: quad takes a word per beat, dual splits it in two
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tx_valid_o <= 1'b0;
			tx_data_o <= '0;
			tx_sop_o <= 1'b0;
			tx_last_o <= 1'b0;
			half_v <= 1'b0;
			half_last <= 1'b0;
			half_w <= '0;
		end else if (ce_i) begin
			tx_valid_o <= take | half_v;
			if (take && !ctrl[CTRL_DUAL]) begin
				tx_data_o <= pend_word[sel];
				tx_sop_o <= pend_sop[sel];
				tx_last_o <= pend_last[sel];
			end else if (take) begin
				tx_data_o <= {2{pend_word[sel][15:0]}};
				tx_sop_o <= pend_sop[sel];
				tx_last_o <= 1'b0;
				half_v <= 1'b1;
				half_w <= pend_word[sel][31:16];
				half_last <= pend_last[sel];
			end else if (half_v) begin
				tx_data_o <= {2{half_w}};
				tx_sop_o <= 1'b0;
				tx_last_o <= half_last;
				half_v <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tx_lane_en_o <= '0;
			tx_clk_lane_en_o <= '0;
		end else if (ce_i) begin
			tx_lane_en_o <= {4{ready}};
			tx_clk_lane_en_o <= {ready & ctrl[CTRL_DUAL], ready};
		end
	end

	// Sticky flags; a new event wins over a clear in the same cycle
	always_comb begin
		fl_set = '0;
		fl_clr = '0;
		for (int p = 0; p < NPORT; p++) begin
			fl_set[FL_OVR + p] = nw_v[p] & pend_v[p] & ~(take && sel == p);
			fl_set[FL_PERR + p] = rx_perr[p];
			fl_set[FL_FWD + p] = rx_fv[p] && fwd_cnt[p] == 3'd7;
		end
		if (wb_wr && idx == REG_FLAGS) fl_clr = wb_dat_i[FL_W-1:0];
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			flags <= '0;
		end else if (ce_i) begin
			flags <= (flags & ~fl_clr) | fl_set;
		end
	end

	// Forward control bits collected into bytes
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			for (int p = 0; p < NPORT; p++) begin
				fwd_sh[p] <= '0;
				fwd_cnt[p] <= '0;
				fwd_byte[p] <= '0;
			end
		end else if (ce_i) begin
			for (int p = 0; p < NPORT; p++) begin
				if (rx_fv[p]) begin
					fwd_sh[p] <= {fwd_sh[p][6:0], port_raw[p] ?
						rx_frame[p][RF_FWD] : rx_frame[p][CF_FWD]};
					fwd_cnt[p] <= fwd_cnt[p] + 3'd1;
					if (fwd_cnt[p] == 3'd7) begin
						fwd_byte[p] <= {fwd_sh[p][6:0], port_raw[p] ?
							rx_frame[p][RF_FWD] : rx_frame[p][CF_FWD]};
					end
				end
			end
		end
	end

	// Back channel: frames run without pause, valid bit clear when nothing queued
	assign bc_top = ctrl[CTRL_SYNC] ? BC_DIV_SYNC : BC_DIV_ASYNC;
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			bc_hold_v <= '0;
			bc_sd_o <= '0;
			for (int p = 0; p < NPORT; p++) begin
				bc_hold_d[p] <= '0;
				bc_div[p] <= '0;
				bc_cnt[p] <= '0;
				bc_sh[p] <= '0;
			end
		end else if (ce_i) begin
			for (int p = 0; p < NPORT; p++) begin
				if (!port_on[p]) begin
					bc_div[p] <= '0;
					bc_cnt[p] <= '0;
					bc_sd_o[p] <= 1'b0;
				// A switch to the shorter cell must not wrap the divider
				end else if (bc_div[p] < bc_top - 8'd1) begin
					bc_div[p] <= bc_div[p] + 8'd1;
				end else if (bc_cnt[p] == 4'd0) begin
					bc_div[p] <= '0;
					bc_cnt[p] <= 4'(BC_FRAME_W - 1);
					bc_sd_o[p] <= BC_SYNC[1];
					bc_sh[p] <= {BC_SYNC[0], bc_hold_v[p],
						bc_hold_v[p] ? bc_hold_d[p] : 8'h00, 1'b0};
					bc_hold_v[p] <= 1'b0;
				end else begin
					bc_div[p] <= '0;
					bc_cnt[p] <= bc_cnt[p] - 4'd1;
					bc_sd_o[p] <= bc_sh[p][BC_FRAME_W-1];
					bc_sh[p] <= {bc_sh[p][BC_FRAME_W-2:0], 1'b0};
				end
				if (wb_wr && idx == REG_BC_TX && port_sel == p &&
					!bc_hold_v[p]) begin
					bc_hold_v[p] <= 1'b1;
					bc_hold_d[p] <= wb_dat_i[7:0];
				end
			end
		end
	end
endmodule

// ### test/dca_aggregator_asserts.sv
// Checker for the aggregator top: bus handshake, lane enables,
// dual-output replication and the power-up wait.
// Assumes one clock domain; bound onto every dca_aggregator.
`timescale 1ns/100ps
module dca_aggregator_asserts import dca_pkg::*; #(
	parameter int unsigned PWRUP_CYCLES = PWRUP_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic power_down_release_pin_i,
	input wire logic tx_valid_o,
	input wire logic [31:0] tx_data_o,
	input wire logic tx_sop_o,
	input wire logic [3:0] tx_lane_en_o,
	input wire logic [1:0] tx_clk_lane_en_o
);
	int unsigned up_cnt;

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	// Saturates so a long run keeps checking that ready holds
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || !power_down_release_pin_i)
			up_cnt <= 0;
		else if (up_cnt < PWRUP_CYCLES + 10)
			up_cnt <= up_cnt + 1;
	end

	sequence s_dual_first;
		tx_valid_o && tx_sop_o && tx_clk_lane_en_o[1];
	endsequence
	sequence s_dual_second;
		tx_valid_o && !tx_sop_o;
	endsequence

	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i
		|=> wb_ack_o) else $error("request not acked next cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");
	a_lanes_ready: assert property (
		tx_clk_lane_en_o[0] |-> tx_lane_en_o == 4'hF)
		else $error("data lanes off while ready");
	a_dual_clock: assert property (
		tx_clk_lane_en_o[1] |-> tx_clk_lane_en_o[0])
		else $error("second clock lane without first");
	a_dual_copy: assert property (
		tx_valid_o && tx_clk_lane_en_o[1] |->
		tx_data_o[31:16] == tx_data_o[15:0])
		else $error("dual halves differ");
	a_dual_pair: assert property (s_dual_first |=> s_dual_second)
		else $error("dual word lacks second beat");
	a_idle_unready: assert property (
		!tx_clk_lane_en_o[0] |-> !tx_valid_o)
		else $error("beat while not ready");
	a_wait_min: assert property (
		$rose(tx_clk_lane_en_o[0]) |-> up_cnt >= PWRUP_CYCLES)
		else $error("ready before power-up wait");
	a_wait_max: assert property (
		up_cnt == PWRUP_CYCLES + 10 |-> tx_clk_lane_en_o[0])
		else $error("ready late after power-up wait");
endmodule

bind dca_aggregator dca_aggregator_asserts #(
	.PWRUP_CYCLES(PWRUP_CYCLES)
) u_chk (
	.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.power_down_release_pin_i(power_down_release_pin_i),
	.tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_sop_o(tx_sop_o),
	.tx_lane_en_o(tx_lane_en_o), .tx_clk_lane_en_o(tx_clk_lane_en_o)
);

// ### test/dca_ser_model.sv
// Behavioural serializer for one link port, plus a back channel watch.
// Assumes callers space frames; the link clock is free of clk_sys_i.
`timescale 1ns/100ps
module dca_ser_model (
	output logic lclk_o,
	output logic lsd_o,
	input wire logic bc_i
);
	int bc_edges;

	initial begin
		lclk_o = 1'b0;
		lsd_o = 1'b1;
		bc_edges = 0;
	end

	always @(posedge bc_i) bc_edges++;

	// MSB first, 160 ns bit; clock stands still between frames.
	// Pins move 1 ns off the system edge so sampling never races.
	task automatic send(input logic [39:0] f, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			#1 lsd_o = f[i];
			#40 lclk_o = 1'b1;
			#80 lclk_o = 1'b0;
			#39;
		end
		lsd_o = ~f[0];
	endtask
endmodule

// ### test/dca_aggregator_tb_top.sv
// Self-checking bench: register bus tasks, two serializer models and
// a beat monitor on the transmit side.
// Assumes the power-up wait shortened to 50 cycles, strap at CSI until
// a last power cycle straps RAW10.
`timescale 1ns/100ps
module dca_aggregator_tb_top import dca_pkg::*; ;
	localparam int PU = 50;
	logic clk_sys_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, pdr;
	logic [2:0] strap;
	logic [9:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, tx_data_o, rd;
	logic wb_ack_o, tx_valid_o, tx_sop_o, tx_last_o;
	logic [3:0] tx_lane_en_o;
	logic [1:0] tx_clk_lane_en_o, bc_sd_o;
	wire [1:0] lclk, lsd;
	logic [33:0] beats[$];
	logic [7:0] ridx[6] = '{REG_CTRL, REG_STAT, REG_PORT_CFG, REG_VC_MAP,
		REG_RAW_HDR, 8'h10};
	logic [7:0] rexp[6] = '{CTRL_RST, 8'h01, PORT_CFG_RST, VC_MAP_RST,
		RAW_HDR_RST, 8'h00};
	int error_cnt = 0;
	int cmp_count = 0;

	dca_aggregator #(.PWRUP_CYCLES(PU)) dut (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.link_clk_i(lclk), .link_sd_i(lsd), .bc_sd_o(bc_sd_o),
		.power_down_release_pin_i(pdr), .mode_strap_i(strap),
		.tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
		.tx_sop_o(tx_sop_o), .tx_last_o(tx_last_o),
		.tx_lane_en_o(tx_lane_en_o), .tx_clk_lane_en_o(tx_clk_lane_en_o)
	);
	dca_ser_model u_ser0 (.lclk_o(lclk[0]), .lsd_o(lsd[0]), .bc_i(bc_sd_o[0]));
	dca_ser_model u_ser1 (.lclk_o(lclk[1]), .lsd_o(lsd[1]), .bc_i(bc_sd_o[1]));

	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end

	always @(posedge clk_sys_i) begin
		if (tx_valid_o === 1'b1)
			beats.push_back({tx_sop_o, tx_last_o, tx_data_o});
	end

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Classic cycle: hold until ack is sampled, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] idx,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= {24'h00_0000, d};
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			error_cnt++;
			end_of_test();
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask

	task automatic beat(input string nm, input logic [1:0] fl,
		input logic [31:0] d, input logic [31:0] m);
		int n;
		logic [33:0] b;
		n = 0;
		while (beats.size() == 0 && n < 20000) begin
			@(posedge clk_sys_i);
			n++;
		end
		if (beats.size() == 0) begin
			error_cnt++;
			end_of_test();
		end
		b = beats.pop_front();
		chk({nm, " flags"}, {30'h0, b[33:32]}, {30'h0, fl});
		chk(nm, b[31:0] & m, d);
	endtask

	function automatic logic [39:0] csi(input logic [1:0] k,
		input logic l, input logic [31:0] p);
		logic [37:0] b;
		b = {k, l, 3'h0, p};
		return {1'b1, ^b, b};
	endfunction

	function automatic logic [39:0] raw(input logic vs, input logic hs,
		input logic [11:0] px);
		logic [25:0] b;
		b = {12'h0, vs, hs, px};
		return {12'h0, 1'b1, ^b, b};
	endfunction

	initial begin
		#400000;
		error_cnt++;
		end_of_test();
	end

	initial begin
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 10'h000;
		wb_dat_i = 32'h0000_0000;
		pdr = 1'b0;
		strap = 3'h0;
		repeat (12) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		pdr <= 1'b1;
		repeat (PU + 20) @(posedge clk_sys_i);
		chk("lanes", {28'h0, tx_lane_en_o}, 32'h0000_000F);
		chk("clk lanes", {30'h0, tx_clk_lane_en_o}, 32'h0000_0001);
		wb(1'b1, REG_STAT, 8'hFF);
		wb(1'b1, 8'h10, 8'hFF);
		for (int i = 0; i < 6; i++) begin
			wb(1'b0, ridx[i], 8'h00);
			chk("reg", rd, {24'h00_0000, rexp[i]});
		end
		wb(1'b1, REG_VC_MAP, 8'h1B);
		wb(1'b1, REG_PORT_SEL, 8'h01);
		wb(1'b1, REG_PORT_CFG, 8'h01);
		wb(1'b1, REG_RAW_HDR, 8'hAE);
		wb(1'b0, REG_PORT_CFG, 8'h00);
		chk("cfg1", rd, 32'h0000_0001);
		wb(1'b1, REG_PORT_SEL, 8'h00);
		wb(1'b0, REG_PORT_CFG, 8'h00);
		chk("cfg0", rd, 32'h0000_0000);
		fork
			begin
				u_ser0.send(csi(2'h2, 1'b0, 32'h0000_042B), 40);
				u_ser0.send(csi(2'h3, 1'b1, 32'hDEAD_BEEF), 40);
			end
			begin
				u_ser1.send(raw(1'b1, 1'b0, 12'h000), 28);
				u_ser1.send(raw(1'b1, 1'b1, 12'h123), 28);
				u_ser1.send(raw(1'b1, 1'b1, 12'hABC), 28);
				u_ser1.send(raw(1'b1, 1'b0, 12'h000), 28);
				u_ser1.send(raw(1'b0, 1'b0, 12'h000), 28);
			end
		join
		beat("fs", 2'b11, {26'h0, DT_FS}, 32'h0000_003F);
		beat("hdr0", 2'b10, 32'h0000_04EB, 32'hFFFF_FFFF);
		beat("dat0", 2'b01, 32'hDEAD_BEEF, 32'hFFFF_FFFF);
		beat("hdr1", 2'b10, 32'h0000_00AB, 32'hFFFF_FFFF);
		beat("pix1", 2'b00, 32'h0000_0ABC, 32'hFFFF_FFFF);
		beat("end1", 2'b01, 32'h0000_0000, 32'hFFFF_FFFF);
		beat("fe", 2'b11, {26'h0, DT_FE}, 32'h0000_003F);
		wb(1'b1, REG_CTRL, 8'h0F);
		chk("dual lanes", {30'h0, tx_clk_lane_en_o}, 32'h0000_0003);
		wb(1'b0, REG_STAT, 8'h00);
		chk("sync", rd, 32'h0000_0003);
		u_ser0.send(csi(2'h1, 1'b0, 32'h0012_3452), 40);
		beat("dual lo", 2'b10, 32'h3492_3492, 32'hFFFF_FFFF);
		beat("dual hi", 2'b01, 32'h0012_0012, 32'hFFFF_FFFF);
		u_ser0.send(csi(2'h1, 1'b0, 32'h0000_0001) ^ (40'h1 << 38), 40);
		repeat (10) @(posedge clk_sys_i);
		chk("dropped", 32'(beats.size()), 32'h0000_0000);
		wb(1'b0, REG_FLAGS, 8'h00);
		chk("perr", rd, 32'h0000_0004);
		wb(1'b1, REG_FLAGS, 8'h04);
		wb(1'b0, REG_FLAGS, 8'h00);
		chk("perr clr", rd, 32'h0000_0000);
		chk("bc0", 32'(u_ser0.bc_edges > 0), 32'h0000_0001);
		chk("bc1", 32'(u_ser1.bc_edges > 0), 32'h0000_0001);
		wb(1'b1, REG_BC_TX, 8'h5A);
		repeat (120) @(posedge clk_sys_i);
		wb(1'b0, REG_STAT, 8'h00);
		chk("bc sent", rd, 32'h0000_0003);
		pdr <= 1'b0;
		strap <= STRAP_RAW10;
		repeat (10) @(posedge clk_sys_i);
		pdr <= 1'b1;
		repeat (PU + 20) @(posedge clk_sys_i);
		wb(1'b0, REG_PORT_CFG, 8'h00);
		chk("strap cfg", rd, {30'h0, RXM_RAW10});
		wb(1'b0, REG_STAT, 8'h00);
		chk("strap stat", rd, 32'h0000_0001);
		end_of_test();
	end
endmodule
